// ### design/pmlr_pkg.sv
// Constants and carrier types for the MII latency and reset block.
//
// Summary of operation
// - 10M receive start nibble within 7 bit times
// - 10M first line bit within 2 bit times; this design takes 4
// - 100M first line bit within 3 bit times; this design takes 5
// - 10M half duplex carrier on within 2 bits
// - 10M half duplex carrier off within 4 bits
// - 100M receive symbol on data within 17 bits
// - Power-on reset completes 40 to 500 ms
// - Reset pin low isolates device after 60 ns
// - Transmit clock valid within 500 ms after release
package pmlr_pkg;

  // ----------------------------------------
  // Clock and bit timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BIT_NS_100      = 10;
  localparam int BIT_NS_10       = 100;
  localparam int BIT_CYC_100     = BIT_NS_100 / CLK_PERIOD_NS;
  localparam int BIT_CYC_10      = BIT_NS_10 / CLK_PERIOD_NS;
  localparam int NIBBLE_BITS     = 4;
  localparam int SYNC_STAGES     = 2;
  localparam int CNT_W           = 26;
  localparam int DIV_W           = 6;

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  localparam int ISOLATE_NS      = 60;
  localparam int ISOLATE_CYC     = (ISOLATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_MS          = 45;
  localparam int POR_CYC         = POR_MS * (1000000 / CLK_PERIOD_NS);
  localparam int HWR_MS          = 35;
  localparam int HWR_CYC         = HWR_MS * (1000000 / CLK_PERIOD_NS);

  // ----------------------------------------
  // Management clock limits
  // ----------------------------------------
  localparam int MDC_HIGH_MIN_NS = 160;
  localparam int MDC_LOW_MIN_NS  = 160;
  localparam int MDC_PER_MIN_NS  = 400;
  localparam int MDC_HIGH_CYC    = (MDC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_LOW_CYC     = (MDC_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_PER_CYC     = (MDC_PER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_CNT_W       = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_POR     = 2'b00,
    ST_ISOLATE = 2'b01,
    ST_INIT    = 2'b10,
    ST_RUN     = 2'b11
  } pmlr_state_t;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } pmlr_mii_tx_t;

  typedef struct packed {
    logic       dv;
    logic [3:0] d;
  } pmlr_mii_rx_t;

  typedef struct packed {
    logic active;
    logic bit_val;
  } pmlr_line_t;

endpackage

// ### design/pmlr_mdc_check.sv
// Management clock phase and period monitor.
`timescale 1ns/1ps
`default_nettype none
module pmlr_mdc_check (
  input  wire logic clock,       // System clock
  input  wire logic srst,        // Synchronous reset
  input  wire logic mdc,         // Management clock pin
  output logic      fault        // Sticky timing fault
);
  localparam logic [pmlr_pkg::MDC_CNT_W-1:0] CNT_MAX = '1;

  logic                          s1_reg, s2_reg, s3_reg;
  logic [pmlr_pkg::MDC_CNT_W-1:0] phase_reg, per_reg;
  logic                          rise, fall;
  logic [1:0]                    fill_reg;

  // Edges count only once all stages hold pin values; reset would fake one
  assign rise = (fill_reg == 2'h3) & s2_reg & ~s3_reg;
  assign fall = (fill_reg == 2'h3) & ~s2_reg & s3_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      s1_reg   <= mdc;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      fill_reg <= (fill_reg == 2'h3) ? 2'h3 : fill_reg + 2'h1;
    end
  end

  // Counters start saturated so the first edge never faults
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_reg <= CNT_MAX;
      per_reg   <= CNT_MAX;
    end else begin
      phase_reg <= (rise | fall) ? '0 : (phase_reg == CNT_MAX ? CNT_MAX : phase_reg + 1'b1);
      per_reg   <= rise ? '0 : (per_reg == CNT_MAX ? CNT_MAX : per_reg + 1'b1);
    end
  end

  // One cycle of slack: sampling can shorten a phase by a cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      fault <= 1'b0;
    end else if (fall && 32'(phase_reg) < pmlr_pkg::MDC_HIGH_CYC - 2) begin
      fault <= 1'b1;
    end else if (rise && 32'(phase_reg) < pmlr_pkg::MDC_LOW_CYC - 2) begin
      fault <= 1'b1;
    end else if (rise && 32'(per_reg) < pmlr_pkg::MDC_PER_CYC - 2) begin
      fault <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### design/pmlr_top.sv
// MII datapath latency, carrier sense and reset sequencing of the PHY.
`timescale 1ns/1ps
`default_nettype none
module pmlr_top #(
  parameter int POR_CYCLES = pmlr_pkg::POR_CYC,  // Power-on reset length
  parameter int HWR_CYCLES = pmlr_pkg::HWR_CYC   // Init length after pin reset
) (
  input  wire logic                 clock,              // 100 MHz system clock
  input  wire logic                 srst,               // Synchronous reset
  input  wire logic                 supply_good,        // Supply above threshold
  input  wire logic                 hw_reset_in_n,      // Hardware reset pin
  input  wire logic                 speed_100,          // 1: 100 Mb/s, 0: 10 Mb/s
  input  wire logic                 half_duplex,        // Half duplex mode
  input  wire logic                 mdc,                // Management clock
  input  wire pmlr_pkg::pmlr_mii_tx_t mii_tx,           // Transmit enable and data
  input  wire pmlr_pkg::pmlr_line_t line_receive_pair,  // Receive line
  output logic                      tx_clk,             // MII transmit clock
  output logic                      rx_clk,             // MII receive clock
  output var pmlr_pkg::pmlr_mii_rx_t mii_rx,            // Receive valid and data
  output logic                      crs,                // Carrier sense
  output logic                      mii_out_en,         // MII outputs driven
  output logic                      phy_ready,          // Reset sequence done
  output var pmlr_pkg::pmlr_line_t  line_transmit_pair, // Transmit line
  output logic                      mdc_timing_fault    // Management clock fault
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = 11;

  logic [PIN_W-1:0] pin1_reg, pin2_reg;
  logic             sup_s, rstn_s, spd_s, hdx_s, txen_s, ract_s, rbit_s;
  logic [3:0]       txd_s;

  always_ff @(posedge clock) begin
    if (srst) begin
      pin1_reg <= '0;
      pin2_reg <= '0;
    end else begin
      pin1_reg <= {supply_good, hw_reset_in_n, speed_100, half_duplex, mii_tx,
                   line_receive_pair};
      pin2_reg <= pin1_reg;
    end
  end

  assign {sup_s, rstn_s, spd_s, hdx_s, txen_s, txd_s, ract_s, rbit_s} = pin2_reg;

  // ----------------------------------------
  // Speed dependent timing
  // ----------------------------------------
  function automatic logic [pmlr_pkg::DIV_W-1:0] bit_cycles(input logic fast);
    bit_cycles = fast ? pmlr_pkg::DIV_W'(pmlr_pkg::BIT_CYC_100)
                      : pmlr_pkg::DIV_W'(pmlr_pkg::BIT_CYC_10);
  endfunction

  function automatic logic [pmlr_pkg::DIV_W-1:0] nib_cycles(input logic fast);
    nib_cycles = pmlr_pkg::DIV_W'(bit_cycles(fast) * pmlr_pkg::NIBBLE_BITS);
  endfunction

  logic [pmlr_pkg::DIV_W-1:0] bit_cyc, nib_cyc;
  assign bit_cyc = bit_cycles(spd_s);
  assign nib_cyc = nib_cycles(spd_s);

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  localparam int ISO_WAIT = pmlr_pkg::ISOLATE_CYC - pmlr_pkg::SYNC_STAGES;

  pmlr_pkg::pmlr_state_t     state_reg;
  logic [pmlr_pkg::CNT_W-1:0] seq_cnt_reg;
  logic [3:0]                low_cnt_reg;
  logic                      ready;

  assign ready = (state_reg == pmlr_pkg::ST_RUN);

  // Pin low time, saturating; the sync stages already cost two cycles
  always_ff @(posedge clock) begin
    if (srst || rstn_s) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != 4'hF) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg   <= pmlr_pkg::ST_POR;
      seq_cnt_reg <= '0;
    end else if (!sup_s) begin
      state_reg   <= pmlr_pkg::ST_POR;
      seq_cnt_reg <= '0;
    end else if (!rstn_s && 32'(low_cnt_reg) >= ISO_WAIT - 1
                 && state_reg != pmlr_pkg::ST_POR) begin
      state_reg   <= pmlr_pkg::ST_ISOLATE;
      seq_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        pmlr_pkg::ST_POR: begin
          if (seq_cnt_reg == pmlr_pkg::CNT_W'(POR_CYCLES - 1)) begin
            state_reg <= pmlr_pkg::ST_RUN;
          end
          seq_cnt_reg <= seq_cnt_reg + 1'b1;
        end
        pmlr_pkg::ST_ISOLATE: begin
          if (rstn_s) begin
            state_reg <= pmlr_pkg::ST_INIT;
          end
          seq_cnt_reg <= '0;
        end
        pmlr_pkg::ST_INIT: begin
          if (seq_cnt_reg == pmlr_pkg::CNT_W'(HWR_CYCLES - 1)) begin
            state_reg <= pmlr_pkg::ST_RUN;
          end
          seq_cnt_reg <= seq_cnt_reg + 1'b1;
        end
        pmlr_pkg::ST_RUN: begin
          seq_cnt_reg <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mii_out_en <= 1'b0;
      phy_ready  <= 1'b0;
    end else begin
      mii_out_en <= (state_reg == pmlr_pkg::ST_INIT) || ready;
      phy_ready  <= ready;
    end
  end

  // ----------------------------------------
  // Transmit clock and path
  // ----------------------------------------
  logic [pmlr_pkg::DIV_W-1:0] tdiv_reg, tbit_reg;
  logic [3:0]                 tsh_reg;
  logic                       tact_reg, tx_sample;

  assign tx_sample = ready && tdiv_reg == '0;

  // Clock held low until the sequence ends; its first high phase is one cycle short
  always_ff @(posedge clock) begin
    if (srst || !ready) begin
      tdiv_reg <= '0;
      tx_clk   <= 1'b0;
    end else begin
      tdiv_reg <= (tdiv_reg >= nib_cyc - 1'b1) ? '0 : tdiv_reg + 1'b1;
      tx_clk   <= (tdiv_reg >= nib_cyc - 1'b1) || (tdiv_reg < (nib_cyc >> 1) - 1'b1);
    end
  end

  // First line bit leaves the cycle after the nibble is sampled
  always_ff @(posedge clock) begin
    if (srst || !ready) begin
      tsh_reg  <= '0;
      tact_reg <= 1'b0;
      tbit_reg <= '0;
    end else if (tx_sample) begin
      tsh_reg  <= txen_s ? txd_s : 4'h0;
      tact_reg <= txen_s;
      tbit_reg <= '0;
    end else if (tbit_reg == bit_cyc - 1'b1) begin
      tsh_reg  <= {1'b0, tsh_reg[3:1]};
      tbit_reg <= '0;
    end else begin
      tbit_reg <= tbit_reg + 1'b1;
    end
  end

  // Idle nibbles load zeros, so the line bit comes straight from a flop
  assign line_transmit_pair = '{active: tact_reg, bit_val: tsh_reg[0]};

  // ----------------------------------------
  // Carrier sense
  // ----------------------------------------
  // Follows the synchronised enable directly in half duplex only, and receive activity: one cycle on, one cycle off
  always_ff @(posedge clock) begin
    if (srst) begin
      crs <= 1'b0;
    end else begin
      crs <= ready && ((hdx_s && txen_s) || ract_s);
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic [pmlr_pkg::DIV_W-1:0] rcnt_reg, rdiv_reg, half_cyc;
  logic [1:0]                 rbits_reg;
  logic [3:0]                 rsh_reg;
  logic                       ract_d_reg, rstart, rsample, rdone;

  assign half_cyc = bit_cyc >> 1;
  assign rstart   = ract_s && !ract_d_reg;
  // No half-bit wait at 100 Mb/s, so the first bit is taken at the start
  assign rsample  = ract_s && (rstart ? (half_cyc == '0) : (rcnt_reg == '0));
  assign rdone    = rsample && rbits_reg == 2'h3;

  // Sample mid-bit; a trailing partial nibble is dropped when activity ends
  always_ff @(posedge clock) begin
    if (srst || !ready) begin
      ract_d_reg <= 1'b0;
      rcnt_reg   <= '0;
      rbits_reg  <= '0;
      rsh_reg    <= '0;
    end else begin
      ract_d_reg <= ract_s;
      if (!ract_s) begin
        rcnt_reg  <= '0;
        rbits_reg <= '0;
      end else if (rsample) begin
        rsh_reg   <= {rbit_s, rsh_reg[3:1]};
        rbits_reg <= rbits_reg + 2'h1;
        rcnt_reg  <= bit_cyc - 1'b1;
      end else if (rstart) begin
        rcnt_reg <= half_cyc - 1'b1;
      end else if (rcnt_reg != '0) begin
        rcnt_reg <= rcnt_reg - 1'b1;
      end
    end
  end

  // Receive clock restarts at each nibble so data lead the rising edge
  always_ff @(posedge clock) begin
    if (srst || !ready) begin
      rdiv_reg <= '0;
      rx_clk   <= 1'b0;
      mii_rx   <= '0;
    end else begin
      if (rdone || rdiv_reg >= nib_cyc - 1'b1) begin
        rdiv_reg <= '0;
      end else begin
        rdiv_reg <= rdiv_reg + 1'b1;
      end
      rx_clk <= !rdone && (rdiv_reg >= (nib_cyc >> 1) - 1'b1)
                && (rdiv_reg < nib_cyc - 1'b1);
      if (!ract_s) begin
        mii_rx.dv <= 1'b0;
      end else if (rdone) begin
        mii_rx.dv <= 1'b1;
        mii_rx.d  <= {rbit_s, rsh_reg[3:1]};
      end
    end
  end

  // ----------------------------------------
  // Management clock monitor
  // ----------------------------------------
  pmlr_mdc_check u_mdc_check (
    .clock (clock),
    .srst  (srst),
    .mdc   (mdc),
    .fault (mdc_timing_fault)
  );

endmodule
`default_nettype wire

// ### verif/pmlr_checker.sv
// Port-level timing checks for the MII latency and reset block.
`timescale 1ns/1ps
`default_nettype none
module pmlr_checker #(
  parameter int POR_CYCLES = 50,  // Power-on count
  parameter int HWR_CYCLES = 40   // Init count
) (
  input wire logic                   clock,              // Clock
  input wire logic                   srst,               // Reset
  input wire logic                   supply_good,        // Supply
  input wire logic                   hw_reset_in_n,      // Reset pin
  input wire logic                   speed_100,          // Speed
  input wire logic                   half_duplex,        // Duplex
  input wire logic                   mdc,                // Mgmt clock
  input wire pmlr_pkg::pmlr_mii_tx_t mii_tx,             // Transmit
  input wire pmlr_pkg::pmlr_line_t   line_receive_pair,  // Line in
  input wire logic                   tx_clk,             // Tx clock
  input wire logic                   rx_clk,             // Rx clock
  input wire pmlr_pkg::pmlr_mii_rx_t mii_rx,             // Receive
  input wire logic                   crs,                // Carrier
  input wire logic                   mii_out_en,         // Not isolated
  input wire logic                   phy_ready,          // Ready
  input wire pmlr_pkg::pmlr_line_t   line_transmit_pair, // Line out
  input wire logic                   mdc_timing_fault    // Mgmt fault
);
  // ----------------------------------------
  // Sequence length counters
  // ----------------------------------------
  logic [31:0] por_cnt_reg;
  logic [31:0] hwr_cnt_reg;

  // Cleared on pin reset so the two paths never mix
  always_ff @(posedge clock) begin
    if (srst || !supply_good || !hw_reset_in_n || phy_ready) begin
      por_cnt_reg <= 32'h0;
    end else if (!mii_out_en) begin
      por_cnt_reg <= por_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !mii_out_en || phy_ready) begin
      hwr_cnt_reg <= 32'h0;
    end else begin
      hwr_cnt_reg <= hwr_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_crs_assert: assert property (
    half_duplex && phy_ready && $rose(mii_tx.en) |-> ##[1:3] crs)
    else $error("carrier sense late");
  chk_crs_release: assert property (
    half_duplex && phy_ready && !line_receive_pair.active && $fell(mii_tx.en) |-> ##[1:3] !crs)
    else $error("carrier sense not released");
  chk_tx_start_100: assert property (
    speed_100 && phy_ready && $rose(mii_tx.en) |-> ##[1:6] line_transmit_pair.active)
    else $error("fast transmit start late");
  chk_tx_start_10: assert property (
    !speed_100 && phy_ready && $rose(mii_tx.en) |-> ##[1:44] line_transmit_pair.active)
    else $error("slow transmit start late");
  chk_rx_lat_100: assert property (
    speed_100 && phy_ready && $rose(line_receive_pair.active) |-> ##[1:17] mii_rx.dv)
    else $error("fast receive latency");
  chk_rx_lat_10: assert property (
    !speed_100 && phy_ready && $rose(line_receive_pair.active) |-> ##[1:70] mii_rx.dv)
    else $error("slow receive latency");
  chk_iso_delay: assert property (
    phy_ready && $fell(hw_reset_in_n) |-> mii_out_en [*3] ##[1:6] !mii_out_en)
    else $error("isolation timing");
  chk_por_len: assert property (
    $rose(phy_ready) && por_cnt_reg > 10 |-> por_cnt_reg >= POR_CYCLES
      && por_cnt_reg <= POR_CYCLES + 8)
    else $error("power-on length");
  chk_init_len: assert property (
    $rose(phy_ready) && hwr_cnt_reg > 4 |-> hwr_cnt_reg >= HWR_CYCLES
      && hwr_cnt_reg <= HWR_CYCLES + 2)
    else $error("init length");
  chk_quiet_unready: assert property (
    !phy_ready && !$past(phy_ready) && !$past(phy_ready, 2) |-> !tx_clk && !crs
      && !mii_rx.dv && !line_transmit_pair.active)
    else $error("outputs active while not ready");
  chk_fault_sticky: assert property (
    mdc_timing_fault |=> mdc_timing_fault)
    else $error("fault dropped");

  cov_fault: cover property ($rose(mdc_timing_fault));
  cov_rx: cover property ($rose(mii_rx.dv));
  cov_iso: cover property ($fell(mii_out_en));
endmodule
`default_nettype wire

// ### verif/pmlr_mac_model.sv
// Behavioural MAC: transmit nibbles and management clock.
`timescale 1ns/1ps
`default_nettype none
module pmlr_mac_model (
  input  wire logic                  clock,     // Clock
  input  wire logic                  tx_clk,    // Tx clock
  input  wire logic                  phy_ready, // Ready
  input  wire logic                  send,      // Keep sending
  input  wire logic [3:0]            nib,       // Nibble
  input  wire logic                  mdc_fast,  // Break the limit
  output var pmlr_pkg::pmlr_mii_tx_t mii_tx,    // Transmit
  output logic                       mdc        // Mgmt clock
);
  logic [4:0] div_reg;

  initial begin
    mii_tx = '0;
    mdc = 1'b0;
    div_reg = 5'h00;
  end

  // Launched only from a running transmit clock
  always @(posedge tx_clk) begin
    mii_tx <= {send && phy_ready, nib};
  end

  // Legal: 200 ns phases; fast: 160 ns period
  always @(posedge clock) begin
    div_reg <= (div_reg >= (mdc_fast ? 5'h07 : 5'h13)) ? 5'h00 : div_reg + 5'h01;
    if (div_reg == 5'h00) mdc <= ~mdc;
  end
endmodule
`default_nettype wire

// ### verif/phy_mii_latency_and_reset_tb_top.sv
// Self-checking bench for the MII latency and reset block.
`timescale 1ns/1ps
`default_nettype none
module phy_mii_latency_and_reset_tb_top;
  localparam int POR_C = 50;
  localparam int HWR_C = 40;
  logic clock, srst, supply_good, hw_reset_in_n, speed_100, half_duplex;
  logic send, mdc_fast, mdc, tx_clk, rx_clk, crs, mii_out_en, phy_ready, fault;
  logic [3:0] nib;
  pmlr_pkg::pmlr_mii_tx_t mii_tx;
  pmlr_pkg::pmlr_mii_rx_t mii_rx;
  pmlr_pkg::pmlr_line_t   line_rx, line_tx;
  int miscompares, checks_done, cycles;

  pmlr_top #(.POR_CYCLES(POR_C), .HWR_CYCLES(HWR_C)) u_dut (
    .clock(clock), .srst(srst), .supply_good(supply_good), .hw_reset_in_n(hw_reset_in_n),
    .speed_100(speed_100), .half_duplex(half_duplex), .mdc(mdc), .mii_tx(mii_tx),
    .line_receive_pair(line_rx), .tx_clk(tx_clk), .rx_clk(rx_clk), .mii_rx(mii_rx),
    .crs(crs), .mii_out_en(mii_out_en), .phy_ready(phy_ready),
    .line_transmit_pair(line_tx), .mdc_timing_fault(fault));

  pmlr_mac_model u_mac (
    .clock(clock), .tx_clk(tx_clk), .phy_ready(phy_ready), .send(send), .nib(nib),
    .mdc_fast(mdc_fast), .mii_tx(mii_tx), .mdc(mdc));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic t_por();
    int n;
    @(posedge clock) srst <= 1'b0;
    @(posedge clock) supply_good <= 1'b1;
    for (n = 0; n < 200 && phy_ready !== 1'b1; n++) tick(1);
    check("power-on length", 8'h01, 8'(n >= POR_C && n <= POR_C + 8));
  endtask

  task automatic t_tx(input logic s100, input logic [3:0] v);
    int n;
    int bc;
    bc = s100 ? 1 : 10;
    @(posedge clock) speed_100 <= s100;
    tick(100);
    @(posedge clock) nib <= v;
    send <= 1'b1;
    for (n = 0; n < 200 && line_tx.active !== 1'b1; n++) tick(1);
    for (n = 0; n < 4; n++) begin
      check("tx bit", 8'(v[n]), 8'(line_tx.bit_val));
      tick(bc);
    end
    check("crs on", 8'h01, 8'(crs));
    @(posedge clock) send <= 1'b0;
    for (n = 0; n < 200 && crs !== 1'b0; n++) tick(1);
    check("crs off", 8'h00, {7'h00, crs});
    tick(50);
    check("tx idle", 8'h00, {7'h00, line_tx.active});
  endtask

  task automatic t_rx(input logic s100, input logic [3:0] v);
    int k, bc, lat, hi;
    logic [3:0] d;
    bc = s100 ? 1 : 10;
    lat = 999;
    hi = 0;
    d = 4'h0;
    @(posedge clock) speed_100 <= s100;
    tick(100);
    for (k = 0; k < 8 * bc; k++) begin
      @(posedge clock) line_rx <= '{1'b1, v[(k / bc) % 4]};
      #1;
      if (rx_clk === 1'b1) hi++;
      if (lat == 999 && mii_rx.dv === 1'b1) begin
        lat = k;
        d = mii_rx.d;
      end
    end
    @(posedge clock) line_rx <= '{1'b0, ~line_rx.bit_val};
    check("rx latency", 8'h01, 8'(lat <= (s100 ? 17 : 70)));
    check("rx nibble", {4'h0, v}, {4'h0, d});
    check("rx clock", 8'h01, 8'(hi > 0 && hi < 8 * bc));
    tick(10);
    check("rx dv off", 8'h00, {7'h00, mii_rx.dv});
  endtask

  task automatic t_hwr();
    int n;
    @(posedge clock) hw_reset_in_n <= 1'b0;
    tick(25); // 260 ns pulse
    check("isolated", 8'h00, {7'h00, mii_out_en});
    @(posedge clock) hw_reset_in_n <= 1'b1;
    for (n = 0; n < 200 && phy_ready !== 1'b1; n++) tick(1);
    check("init length", 8'h01, 8'(n >= HWR_C && n <= HWR_C + 8));
  endtask

  task automatic t_fdx();
    int n;
    @(posedge clock) half_duplex <= 1'b0;
    send <= 1'b1;
    for (n = 0; n < 200 && line_tx.active !== 1'b1; n++) tick(1);
    check("tx full duplex", 8'h01, {7'h00, line_tx.active});
    check("crs full duplex", 8'h00, {7'h00, crs});
    @(posedge clock) send <= 1'b0;
    tick(60);
    @(posedge clock) half_duplex <= 1'b1;
    tick(10);
  endtask

  task automatic t_mdc();
    check("fault legal", 8'h00, {7'h00, fault});
    @(posedge clock) mdc_fast <= 1'b1;
    tick(60);
    check("fault fast", 8'h01, {7'h00, fault});
    @(posedge clock) srst <= 1'b1;
    mdc_fast <= 1'b0;
    tick(2);
    @(posedge clock) srst <= 1'b0;
    tick(100);
    check("fault cleared", 8'h00, {7'h00, fault});
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard well above the thousand or so cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    {srst, supply_good, hw_reset_in_n, speed_100, half_duplex} = 5'b10111;
    {send, mdc_fast, nib, line_rx} = 8'h00;
    tick(2);
    t_por();
    t_tx(1'b1, 4'hA);
    t_rx(1'b1, 4'h5);
    t_tx(1'b0, 4'h6);
    t_rx(1'b0, 4'hC);
    t_fdx();
    t_hwr();
    t_mdc();
    give_verdict();
  end
endmodule

bind pmlr_top pmlr_checker #(.POR_CYCLES(POR_CYCLES), .HWR_CYCLES(HWR_CYCLES)) u_chk (
  .clock(clock), .srst(srst), .supply_good(supply_good), .hw_reset_in_n(hw_reset_in_n),
  .speed_100(speed_100), .half_duplex(half_duplex), .mdc(mdc), .mii_tx(mii_tx),
  .line_receive_pair(line_receive_pair), .tx_clk(tx_clk), .rx_clk(rx_clk),
  .mii_rx(mii_rx), .crs(crs), .mii_out_en(mii_out_en), .phy_ready(phy_ready),
  .line_transmit_pair(line_transmit_pair), .mdc_timing_fault(mdc_timing_fault));
`default_nettype wire
